// ---- logic/mode_seq_cfg.svh ----
// register map, field positions, reset values and step times of the mode sequencer
`ifndef MODE_SEQ_CFG_SVH
`define MODE_SEQ_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_DEV_STAT 7'h02
`define ADDR_EVT1 7'h03
`define ADDR_EVT2 7'h04
`define ADDR_MASK1 7'h05
`define ADDR_MASK2 7'h06
`define ADDR_MODE 7'h07
`define ADDR_CAL 7'h5a

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_MASK1 8'h00
`define RST_MASK2 8'h01
`define RST_MODE 8'h01
`define RST_EVT 8'h00
`define RST_CAL_EN 1'h1

// ----------------------------------------
// field positions
// ----------------------------------------
`define MODE_SWRST 3'h7
`define MODE_WAKE 3'h6
`define MODE_BATT 3'h5
`define MODE_TEMP 3'h4
`define MODE_TX 3'h3
`define MODE_RX 3'h2
`define MODE_PLL 3'h1
`define MODE_XTAL 3'h0
`define EVT2_CHIPRDY 3'h1
`define EVT2_POR 3'h0
`define CAL_EN_BIT 3'h0
`define SPI_RW_BIT 3'h7
`define SPI_LAST_BIT 3'h7
`define CPS_IDLE 2'h0
`define CPS_RX 2'h1
`define CPS_TX 2'h2

// ----------------------------------------
// timing, microseconds as printed, clock in MHz
// ----------------------------------------
`define CLK_MHZ 100
`define T_SHUT_TO_ACT_US 16800
`define T_STANDBY_TO_ACT_US 800
`define T_READY_TO_ACT_US 200
`define T_PLL_TS_US 100
`define T_VCO_CAL_US 50
`define T_PA_RAMP_US 5
`define TMR_W 21
`define TMR_ONE 21'h00_0001

`endif

// ---- logic/mode_seq_pkg.sv ----
// types shared by the mode sequencer, its serial link and its step timer
`include "mode_seq_cfg.svh"
package mode_seq_pkg;
	typedef logic [`TMR_W-1:0] tcount_t;

	typedef enum logic [3:0] {
		ST_SHUT, ST_POR, ST_IDLE, ST_XTAL, ST_PLL_T0, ST_VCO_CAL,
		ST_PLL_TS, ST_PA_RAMP, ST_TX, ST_RX_EN, ST_RX
	} seq_state_t;

	typedef enum logic [2:0] {
		IDLE_STANDBY, IDLE_SLEEP, IDLE_SENSOR, IDLE_READY, IDLE_TUNE
	} idle_mode_t;

	typedef struct packed {
		logic main_reg_en;
		logic low_power_regulator;
		logic xtal_en;
		logic pll_en;
		logic vco_cal_en;
		logic pa_en;
		logic rx_front_en;
		logic modem_rx_en;
		logic wake_timer_en;
		logic batt_mon_en;
		logic temp_sense_en;
	} power_ctl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] data;
	} reg_req_t;

	typedef struct packed {
		logic [2:0] sclk_s;
		logic [1:0] sdi_s;
		logic [1:0] sel_s;
		logic [2:0] bitcnt;
		logic addr_done;
		logic write;
		logic [6:0] cur;
		logic [7:0] shin;
		logic [7:0] shout;
		logic sdo;
		reg_req_t req;
	} spi_state_t;

	typedef struct packed {
		tcount_t cnt;
		logic busy;
		logic done;
	} timer_state_t;

	typedef struct packed {
		logic [1:0] shdn_s;
		seq_state_t st;
		logic [7:0] mode;
		logic [7:0] mask1;
		logic [7:0] mask2;
		logic [7:0] evt1;
		logic [7:0] evt2;
		logic cal_en;
		logic xtal_run;
		power_ctl_t pwr;
		logic [1:0] cps;
		logic irq_n;
	} seq_regs_t;
endpackage

// ---- logic/radio_mode_sequencer_irq.sv ----
// operating-mode sequencer, register file and interrupt line of the radio
`timescale 1ns/100ps
`include "mode_seq_cfg.svh"
// ----------------------------------------
// ----------------------------------------
module radio_mode_sequencer_irq
	import mode_seq_pkg::*;
#(
	parameter int POR_CYC = (`T_SHUT_TO_ACT_US - `T_STANDBY_TO_ACT_US) * `CLK_MHZ,
	parameter int XTAL_CYC = (`T_STANDBY_TO_ACT_US - `T_READY_TO_ACT_US) * `CLK_MHZ,
	parameter int PLL_T0_CYC = (`T_READY_TO_ACT_US - `T_PLL_TS_US - `T_VCO_CAL_US
		- `T_PA_RAMP_US) * `CLK_MHZ,
	parameter int VCO_CAL_CYC = `T_VCO_CAL_US * `CLK_MHZ,
	parameter int PLL_TS_CYC = `T_PLL_TS_US * `CLK_MHZ
)(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic shutdown_pin,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sel_n,
	output logic sdo,
	output logic interrupt_out_n,
	input wire logic [7:0] evt_first,
	input wire logic [5:0] evt_second_ext,
	input wire logic [4:0] dev_flags,
	output power_ctl_t pwr,
	output logic [1:0] chip_power_state
);
	localparam int PA_RAMP_CYC = `T_PA_RAMP_US * `CLK_MHZ;

	seq_regs_t r;
	seq_regs_t n;
	reg_req_t req;
	logic [7:0] rd_data;
	logic [7:0] set1;
	logic [7:0] set2;
	logic want_tx;
	logic want_rx;
	logic want_act;
	logic swrst;
	logic keep_xtal;
	idle_mode_t idle_sel;
	idle_mode_t idle_n;
	logic tmr_load;
	tcount_t tmr_cyc;
	logic tmr_done;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// most active request wins; standby is what is left
	function automatic idle_mode_t idle_of(input logic [7:0] m);
		if (m[`MODE_PLL])
			return IDLE_TUNE;
		else if (m[`MODE_XTAL])
			return IDLE_READY;
		else if (m[`MODE_BATT] | m[`MODE_TEMP])
			return IDLE_SENSOR;
		else if (m[`MODE_WAKE])
			return IDLE_SLEEP;
		else
			return IDLE_STANDBY;
	endfunction

	// contents that shutdown and software reset bring back
	function automatic seq_regs_t with_defaults(input seq_regs_t cur);
		seq_regs_t d;
		d = cur;
		d.mode = `RST_MODE;
		d.mask1 = `RST_MASK1;
		d.mask2 = `RST_MASK2;
		d.evt1 = `RST_EVT;
		d.evt2 = `RST_EVT;
		d.cal_en = `RST_CAL_EN;
		return d;
	endfunction

	// ----------------------------------------
	// serial link and step timer
	// ----------------------------------------
	// link is held quiet in shutdown, so no access gets through
	spi_frame u_link (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.ce(ce),
		.hold(r.shdn_s[1]),
		.sclk(sclk),
		.sdi(sdi),
		.sel_n(sel_n),
		.rd_data(rd_data),
		.req(req),
		.sdo(sdo)
	);

	step_timer u_timer (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.ce(ce),
		.clear(r.shdn_s[1]),
		.load(tmr_load),
		.cycles(tmr_cyc),
		.done(tmr_done)
	);

	// ----------------------------------------
	// register read mux
	// ----------------------------------------
	// reserved status bit reads zero
	always_comb begin
		case (req.addr)
			`ADDR_DEV_STAT: rd_data = {dev_flags, 1'h0, r.cps};
			`ADDR_EVT1: rd_data = r.evt1;
			`ADDR_EVT2: rd_data = r.evt2;
			`ADDR_MASK1: rd_data = r.mask1;
			`ADDR_MASK2: rd_data = r.mask2;
			`ADDR_MODE: rd_data = r.mode;
			`ADDR_CAL: rd_data = {7'h00, r.cal_en};
			default: rd_data = '0;
		endcase
	end

	// ----------------------------------------
	// sequencer, registers and event flags
	// ----------------------------------------
	always_comb begin
		n = r;
		tmr_load = 1'b0;
		tmr_cyc = '0;
		set1 = evt_first;
		set2 = {evt_second_ext, 2'h0};
		want_tx = r.mode[`MODE_TX];
		want_rx = r.mode[`MODE_RX] & ~r.mode[`MODE_TX];
		want_act = r.mode[`MODE_TX] | r.mode[`MODE_RX];
		swrst = req.wr && req.addr == `ADDR_MODE && req.data[`MODE_SWRST];
		idle_sel = idle_of(r.mode);
		keep_xtal = idle_sel == IDLE_READY || idle_sel == IDLE_TUNE;
		n.shdn_s = {r.shdn_s[0], shutdown_pin};

		// host writes; flag registers ignore writes
		if (req.wr) begin
			case (req.addr)
				`ADDR_MASK1: n.mask1 = req.data;
				`ADDR_MASK2: n.mask2 = req.data;
				`ADDR_MODE: n.mode = req.data & ~(8'h01 << `MODE_SWRST);
				`ADDR_CAL: n.cal_en = req.data[`CAL_EN_BIT];
				default: ;
			endcase
		end

		// reading a flag register clears only its enabled flags
		if (req.rd && req.addr == `ADDR_EVT1) begin
			n.evt1 = r.evt1 & ~r.mask1;
		end
		if (req.rd && req.addr == `ADDR_EVT2) begin
			n.evt2 = r.evt2 & ~r.mask2;
		end

		// step machine; each timed step waits on the one-shot timer
		unique case (r.st)
			ST_SHUT: ;
			ST_POR: begin
				if (tmr_done) begin
					set2[`EVT2_POR] = 1'b1;
					n.st = ST_XTAL;
					tmr_load = 1'b1;
					tmr_cyc = tcount_t'(XTAL_CYC);
				end
			end
			ST_IDLE: begin
				if ((want_act || keep_xtal) && !r.xtal_run) begin
					n.st = ST_XTAL;
					tmr_load = 1'b1;
					tmr_cyc = tcount_t'(XTAL_CYC);
				end else if (want_act) begin
					n.st = ST_PLL_T0;
					tmr_load = 1'b1;
					tmr_cyc = tcount_t'(PLL_T0_CYC);
				end else if (!keep_xtal) begin
					n.xtal_run = 1'b0;
				end
			end
			ST_XTAL: begin
				if (tmr_done) begin
					set2[`EVT2_CHIPRDY] = 1'b1;
					n.xtal_run = 1'b1;
					if (want_act) begin
						n.st = ST_PLL_T0;
						tmr_load = 1'b1;
						tmr_cyc = tcount_t'(PLL_T0_CYC);
					end else begin
						n.st = ST_IDLE;
					end
				end
			end
			ST_PLL_T0: begin
				if (tmr_done && r.cal_en) begin
					n.st = ST_VCO_CAL;
					tmr_load = 1'b1;
					tmr_cyc = tcount_t'(VCO_CAL_CYC);
				end else if (tmr_done) begin
					n.st = ST_PLL_TS;
					tmr_load = 1'b1;
					tmr_cyc = tcount_t'(PLL_TS_CYC);
				end
			end
			ST_VCO_CAL: begin
				if (tmr_done) begin
					n.st = ST_PLL_TS;
					tmr_load = 1'b1;
					tmr_cyc = tcount_t'(PLL_TS_CYC);
				end
			end
			ST_PLL_TS: begin
				if (tmr_done) begin
					n.st = want_tx ? ST_PA_RAMP : ST_RX_EN;
					tmr_load = 1'b1;
					tmr_cyc = tcount_t'(PA_RAMP_CYC);
				end
			end
			ST_PA_RAMP: begin
				if (tmr_done) begin
					n.st = ST_TX;
				end
			end
			ST_RX_EN: begin
				if (tmr_done) begin
					n.st = ST_RX;
				end
			end
			ST_TX: begin
				if (!want_tx) begin
					n.st = ST_IDLE;
				end
			end
			ST_RX: begin
				if (!want_rx) begin
					n.st = ST_IDLE;
				end
			end
		endcase

		// software reset drops any sequence back to idle ready
		if (swrst) begin
			n = with_defaults(n);
			n.st = ST_IDLE;
		end

		// a new event beats a clear in the same cycle
		n.evt1 = n.evt1 | set1;
		n.evt2 = n.evt2 | set2;

		// shutdown overrides everything; its release starts power-on
		if (r.shdn_s[1]) begin
			n = with_defaults(n);
			n.st = ST_SHUT;
			n.xtal_run = 1'b0;
		end else if (r.st == ST_SHUT) begin
			n.st = ST_POR;
			tmr_load = 1'b1;
			tmr_cyc = tcount_t'(POR_CYC);
		end

		// supplies and enables follow the next state
		idle_n = idle_of(n.mode);
		n.pwr.low_power_regulator = n.st != ST_SHUT;
		n.pwr.main_reg_en = n.st != ST_SHUT && !(n.st == ST_IDLE
			&& (idle_n == IDLE_STANDBY || idle_n == IDLE_SLEEP));
		n.pwr.xtal_en = (n.st inside {ST_XTAL, ST_PLL_T0, ST_VCO_CAL, ST_PLL_TS,
			ST_PA_RAMP, ST_TX, ST_RX_EN, ST_RX}) || (n.st == ST_IDLE && n.xtal_run);
		n.pwr.pll_en = (n.st inside {ST_PLL_T0, ST_VCO_CAL, ST_PLL_TS, ST_PA_RAMP,
			ST_TX, ST_RX_EN, ST_RX})
			|| (n.st == ST_IDLE && idle_n == IDLE_TUNE && n.xtal_run);
		n.pwr.vco_cal_en = n.st == ST_VCO_CAL;
		n.pwr.pa_en = n.st == ST_PA_RAMP || n.st == ST_TX;
		n.pwr.rx_front_en = n.st == ST_RX_EN || n.st == ST_RX;
		n.pwr.modem_rx_en = n.st == ST_RX;
		n.pwr.wake_timer_en = n.st != ST_SHUT && n.mode[`MODE_WAKE];
		n.pwr.batt_mon_en = n.st != ST_SHUT && n.mode[`MODE_BATT];
		n.pwr.temp_sense_en = n.st != ST_SHUT && n.mode[`MODE_TEMP];
		n.cps = n.st == ST_TX ? `CPS_TX : (n.st == ST_RX ? `CPS_RX : `CPS_IDLE);
		n.irq_n = ~|((n.evt1 & n.mask1) | (n.evt2 & n.mask2));
	end

	// starts in shutdown with the pin chain reading low, so power-on begins at once and a high pin stops it two cycles later
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
			r.mode <= `RST_MODE;
			r.mask2 <= `RST_MASK2;
			r.cal_en <= `RST_CAL_EN;
			r.irq_n <= 1'b1;
		end else if (ce) begin
			r <= n;
		end
	end

	assign interrupt_out_n = r.irq_n;
	assign pwr = r.pwr;
	assign chip_power_state = r.cps;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic quiet;
	assign quiet = ce && !r.shdn_s[1] && !req.wr;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	property p_shut_enter;
		ce && r.shdn_s[1] |=> r.st == ST_SHUT && r.mode == `RST_MODE && !r.pwr.main_reg_en;
	endproperty
	a_shut_enter: assert property (p_shut_enter) else $error("pin did not shut down");

	property p_por_start;
		ce && !r.shdn_s[1] && r.st == ST_SHUT |=> r.st == ST_POR;
	endproperty
	a_por_start: assert property (p_por_start) else $error("no power-on after pin fall");

	sequence s_por_end;
		quiet && r.st == ST_POR && tmr_done;
	endsequence
	property p_ready_default;
		s_por_end |=> r.st == ST_XTAL && r.evt2[`EVT2_POR] && r.mode == `RST_MODE;
	endproperty
	a_ready_default: assert property (p_ready_default) else $error("not ready after reset");

	property p_main_reg;
		r.st != ST_SHUT |-> r.pwr.main_reg_en == !(r.st == ST_IDLE
			&& (idle_of(r.mode) == IDLE_STANDBY || idle_of(r.mode) == IDLE_SLEEP));
	endproperty
	a_main_reg: assert property (p_main_reg) else $error("main regulator wrong");

	property p_skip_xtal;
		quiet && r.st == ST_IDLE && r.xtal_run && want_act |=> r.st == ST_PLL_T0;
	endproperty
	a_skip_xtal: assert property (p_skip_xtal) else $error("crystal step not skipped");

	property p_cal_skip;
		quiet && r.st == ST_PLL_T0 && tmr_done && !r.cal_en |=> r.st == ST_PLL_TS;
	endproperty
	a_cal_skip: assert property (p_cal_skip) else $error("calibration not skipped");

	sequence s_settled_tx;
		quiet && r.st == ST_PLL_TS && tmr_done && want_tx;
	endsequence
	property p_tx_path;
		s_settled_tx |=> r.st == ST_PA_RAMP && r.pwr.pa_en && r.pwr.pll_en;
	endproperty
	a_tx_path: assert property (p_tx_path) else $error("transmit ramp missing");

	sequence s_settled_rx;
		quiet && r.st == ST_PLL_TS && tmr_done && !want_tx;
	endsequence
	property p_rx_path;
		s_settled_rx |=> r.st == ST_RX_EN && r.pwr.rx_front_en && !r.pwr.pa_en;
	endproperty
	a_rx_path: assert property (p_rx_path) else $error("receive front end missing");

	property p_irq_line;
		interrupt_out_n == !(|((r.evt1 & r.mask1) | (r.evt2 & r.mask2)));
	endproperty
	a_irq_line: assert property (p_irq_line) else $error("interrupt line wrong");

	property p_read_clear;
		ce && !r.shdn_s[1] && req.rd && req.addr == `ADDR_EVT1
			|=> (r.evt1 & $past(r.mask1) & ~$past(evt_first)) == 8'h00;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("enabled flags kept");

	property p_masked_kept;
		quiet |=> ($past(r.evt1) & ~$past(r.mask1) & ~r.evt1) == 8'h00;
	endproperty
	a_masked_kept: assert property (p_masked_kept) else $error("masked flag lost");

	property p_tune;
		r.st == ST_IDLE && idle_of(r.mode) == IDLE_TUNE && r.xtal_run
			|-> r.pwr.xtal_en && r.pwr.pll_en;
	endproperty
	a_tune: assert property (p_tune) else $error("tune lacks crystal or pll");
endmodule

// ---- logic/spi_frame.sv ----
// serial register link: frames host accesses into register read and write requests
`timescale 1ns/100ps
`include "mode_seq_cfg.svh"
module spi_frame
	import mode_seq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic hold,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sel_n,
	input wire logic [7:0] rd_data,
	output reg_req_t req,
	output logic sdo
);
	spi_state_t r;
	spi_state_t n;
	logic [7:0] byte_in;
	logic rise;
	logic fall;

	// edges look only at stages two and three of the pin chains
	always_comb begin
		n = r;
		rise = r.sclk_s[1] & ~r.sclk_s[2];
		fall = ~r.sclk_s[1] & r.sclk_s[2];
		byte_in = {r.shin[6:0], r.sdi_s[1]};
		n.sclk_s = {r.sclk_s[1:0], sclk};
		n.sdi_s = {r.sdi_s[0], sdi};
		n.sel_s = {r.sel_s[0], sel_n};
		n.req.wr = 1'b0;
		n.req.rd = 1'b0;
		// read data arrives one cycle after the request
		if (r.req.rd) begin
			n.shout = rd_data;
		end
		if (hold || r.sel_s[1]) begin
			n.bitcnt = '0;
			n.addr_done = 1'b0;
			n.sdo = 1'b1;
		end else if (rise) begin
			n.shin = byte_in;
			n.bitcnt = r.bitcnt + 3'h1;
			if (r.bitcnt == `SPI_LAST_BIT) begin
				if (!r.addr_done) begin
					// first byte: select bit then address
					n.addr_done = 1'b1;
					n.write = byte_in[`SPI_RW_BIT];
					n.req.addr = byte_in[6:0];
					n.req.rd = ~byte_in[`SPI_RW_BIT];
					n.cur = byte_in[6:0] + {6'h00, ~byte_in[`SPI_RW_BIT]};
				end else begin
					// later bytes: burst walks the address upward
					n.req.addr = r.cur;
					n.req.data = byte_in;
					n.req.wr = r.write;
					n.req.rd = ~r.write;
					n.cur = r.cur + 7'h01;
				end
			end
		end else if (fall && r.addr_done && !r.write) begin
			n.sdo = r.shout[7];
			n.shout = {r.shout[6:0], 1'b0};
		end
	end

	// idle line reads high while deselected
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
			r.sel_s <= 2'h3;
			r.sdo <= 1'b1;
		end else if (ce) begin
			r <= n;
		end
	end

	assign req = r.req;
	assign sdo = r.sdo;
endmodule

// ---- logic/step_timer.sv ----
// one-shot step timer: counts a loaded number of cycles, then pulses done
`timescale 1ns/100ps
`include "mode_seq_cfg.svh"
module step_timer
	import mode_seq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic clear,
	input wire logic load,
	input wire tcount_t cycles,
	output logic done
);
	timer_state_t r;
	timer_state_t n;

	// a reload wins over a running count
	always_comb begin
		n = r;
		n.done = 1'b0;
		if (clear) begin
			n.busy = 1'b0;
		end else if (load) begin
			n.cnt = cycles;
			n.busy = 1'b1;
		end else if (r.busy) begin
			n.cnt = r.cnt - `TMR_ONE;
			if (r.cnt <= `TMR_ONE) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end
	end

	// ce low freezes the count
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	assign done = r.done;
endmodule

// ---- sim/host_link_model.sv ----
// host side model: serial register frames toward the radio
`timescale 1ns/100ps
module host_link_model (
	input wire logic clk_sys,
	input wire logic sdo,
	output logic sclk,
	output logic sdi,
	output logic sel_n
);
	// link clock stands still low between frames
	initial begin
		sclk = 1'b0;
		sdi = 1'b0;
		sel_n = 1'b1;
	end

	// wait whole system cycles, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// one frame, msb first; sdo is taken late in the low phase, after it settled
	task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		logic [15:0] fr;
		fr = {wr, addr, wdata};
		rdata = 8'h00;
		sel_n = 1'b0;
		tick(8);
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			sdi = fr[i];
			tick(8); // 80 ns low, twice the minimum
			if (i < 8) begin
				rdata[i] = sdo;
			end
			sclk = 1'b1;
			tick(8);
		end
		sclk = 1'b0;
		tick(8);
		sel_n = 1'b1;
		sdi = ~sdi; // released line must not look like held data
		tick(10); // deselect gap above 80 ns
	endtask
endmodule

// ---- sim/test_radio_mode_sequencer_irq.sv ----
// self-checking bench for the radio mode sequencer and its interrupt line
`timescale 1ns/100ps
`include "mode_seq_cfg.svh"
module test_radio_mode_sequencer_irq;
	import mode_seq_pkg::*;
	// shortened step counts keep the run small; RAMP stays the full 500-cycle ramp of the design
	localparam int POR = 200;
	localparam int XT = 50;
	localparam int T0 = 10;
	localparam int CAL = 10;
	localparam int TS = 20;
	localparam int RAMP = 500;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic shutdown_pin = 1'b1;
	logic sclk, sdi, sel_n, sdo, interrupt_out_n;
	logic [7:0] evt_first = 8'h00;
	logic [5:0] evt_second_ext = 6'h00;
	logic [4:0] dev_flags = 5'h00;
	power_ctl_t pwr;
	logic [1:0] chip_power_state;
	logic [7:0] rd;
	int fails = 0;
	int total_checks = 0;

	always #5 clk_sys = ~clk_sys;

	radio_mode_sequencer_irq #(.POR_CYC(POR), .XTAL_CYC(XT), .PLL_T0_CYC(T0),
		.VCO_CAL_CYC(CAL), .PLL_TS_CYC(TS)) i_radio_mode_sequencer_irq (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .shutdown_pin(shutdown_pin),
		.sclk(sclk), .sdi(sdi), .sel_n(sel_n), .sdo(sdo), .interrupt_out_n(interrupt_out_n),
		.evt_first(evt_first), .evt_second_ext(evt_second_ext), .dev_flags(dev_flags),
		.pwr(pwr), .chip_power_state(chip_power_state));

	host_link_model i_host_link_model (.clk_sys(clk_sys), .sdo(sdo), .sclk(sclk), .sdi(sdi),
		.sel_n(sel_n));

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic wrap_up();
		if (fails == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic win(input int n, input int lo, input int hi);
		chk({7'h00, n >= lo && n <= hi}, 8'h01);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_host_link_model.xfer(1'b1, a, d, rd);
	endtask

	task automatic rdreg(input logic [6:0] a, input logic [7:0] exp);
		i_host_link_model.xfer(1'b0, a, 8'h00, rd);
		chk(rd, exp);
	endtask

	task automatic pulse_first(input logic [7:0] v);
		evt_first = v;
		i_host_link_model.tick(1);
		evt_first = 8'h00;
		i_host_link_model.tick(2);
	endtask

	// bounded wait on chip power state or the interrupt line; a hang ends the run
	task automatic wait_for(input logic sel_cps, input logic [1:0] exp, output int n);
		n = 0;
		while ((sel_cps ? chip_power_state : {1'b0, interrupt_out_n}) !== exp) begin
			i_host_link_model.tick(1);
			n++;
			if (n > 5000) begin
				fails++;
				wrap_up();
			end
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// power-up from shutdown: flags, default masks and ready mode
	task automatic t_por();
		int n;
		shutdown_pin = 1'b0;
		wait_for(1'b0, 2'b00, n);
		win(n, POR, POR + 8);
		i_host_link_model.tick(XT + 20);
		rdreg(`ADDR_EVT2, 8'h03);
		chk({7'h00, interrupt_out_n}, 8'h01);
		rdreg(`ADDR_EVT2, 8'h02);
		rdreg(`ADDR_MASK1, 8'h00);
		rdreg(`ADDR_MASK2, 8'h01);
		rdreg(`ADDR_MODE, 8'h01);
		chk({6'h00, pwr.main_reg_en, pwr.xtal_en}, 8'h03);
	endtask

	// masked and unmasked events, status register, refused writes
	task automatic t_irq();
		wr(`ADDR_MASK1, 8'h81);
		pulse_first(8'h05);
		chk({7'h00, interrupt_out_n}, 8'h00);
		rdreg(`ADDR_EVT1, 8'h05);
		chk({7'h00, interrupt_out_n}, 8'h01);
		rdreg(`ADDR_EVT1, 8'h04);
		pulse_first(8'h04);
		chk({7'h00, interrupt_out_n}, 8'h01);
		evt_second_ext = 6'h01;
		i_host_link_model.tick(1);
		evt_second_ext = 6'h00;
		rdreg(`ADDR_EVT2, 8'h06);
		dev_flags = 5'h15;
		rdreg(`ADDR_DEV_STAT, 8'ha8);
		wr(`ADDR_DEV_STAT, 8'hff);
		rdreg(`ADDR_DEV_STAT, 8'ha8);
		dev_flags = 5'h00;
		rdreg(7'h40, 8'h00);
	endtask

	// idle sub-modes and their regulators
	task automatic t_modes();
		wr(`ADDR_MODE, 8'h00);
		i_host_link_model.tick(5);
		chk({5'h00, pwr.main_reg_en, pwr.low_power_regulator, pwr.xtal_en}, 8'h02);
		wr(`ADDR_MODE, 8'h40);
		i_host_link_model.tick(5);
		chk({6'h00, pwr.main_reg_en, pwr.wake_timer_en}, 8'h01);
		wr(`ADDR_MODE, 8'h20);
		i_host_link_model.tick(5);
		chk({6'h00, pwr.main_reg_en, pwr.batt_mon_en}, 8'h03);
		wr(`ADDR_MODE, 8'h02);
		i_host_link_model.tick(150);
		chk({6'h00, pwr.pll_en, pwr.xtal_en}, 8'h03);
	endtask

	// transmit from ready, receive from standby without calibration, priority
	task automatic t_seq();
		int n;
		wr(`ADDR_MODE, 8'h01);
		i_host_link_model.tick(100);
		wr(`ADDR_MODE, 8'h09);
		wait_for(1'b1, 2'b10, n);
		win(n, T0 + CAL + TS + RAMP - 30, T0 + CAL + TS + RAMP);
		chk({7'h00, pwr.pa_en}, 8'h01);
		wr(`ADDR_MODE, 8'h01);
		chk({6'h00, chip_power_state}, 8'h00);
		wr(`ADDR_CAL, 8'h00);
		rdreg(`ADDR_CAL, 8'h00);
		wr(`ADDR_MODE, 8'h00);
		wr(`ADDR_MODE, 8'h04);
		wait_for(1'b1, 2'b01, n);
		win(n, XT + T0 + TS + RAMP - 30, XT + T0 + TS + RAMP);
		chk({6'h00, pwr.rx_front_en, pwr.modem_rx_en}, 8'h03);
		rdreg(`ADDR_DEV_STAT, 8'h01);
		wr(`ADDR_MODE, 8'h00);
		wr(`ADDR_MODE, 8'h0f);
		wait_for(1'b1, 2'b10, n);
		wr(`ADDR_MODE, 8'h01);
	endtask

	// software reset, then shutdown losing registers and access
	task automatic t_shut();
		int n;
		wr(`ADDR_MASK1, 8'h55);
		wr(`ADDR_MODE, 8'h80);
		rdreg(`ADDR_MODE, 8'h01);
		rdreg(`ADDR_MASK1, 8'h00);
		wr(`ADDR_MASK1, 8'h55);
		shutdown_pin = 1'b1;
		i_host_link_model.tick(5);
		chk(pwr[7:0], 8'h00);
		chk({5'h00, pwr[10:8]}, 8'h00);
		wr(`ADDR_MASK2, 8'hff);
		shutdown_pin = 1'b0;
		wait_for(1'b0, 2'b00, n);
		i_host_link_model.tick(XT + 20);
		rdreg(`ADDR_MASK1, 8'h00);
		rdreg(`ADDR_MASK2, 8'h01);
		rdreg(`ADDR_MODE, 8'h01);
		// enable low freezes the pin chain, so a short pin pulse is never seen
		ce = 1'b0;
		shutdown_pin = 1'b1;
		i_host_link_model.tick(10);
		chk({7'h00, pwr.main_reg_en}, 8'h01);
		shutdown_pin = 1'b0;
		ce = 1'b1;
		i_host_link_model.tick(5);
		chk({7'h00, pwr.main_reg_en}, 8'h01);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		i_host_link_model.tick(10);
		t_por();
		t_irq();
		t_modes();
		t_seq();
		t_shut();
		wrap_up();
	end
endmodule
